// [design/ccsg_core.sv]
// Overview of operation
// - Five-phase shift register launched by start pulse
// - Read in phases one-two, write three-four
// - Address cores set with read at phase one
// - Phase two strobe captures sense into register
// - Write phases three-four; master resets at three
// - Inhibit planes whose bit must stay cleared
// - Ten address terms: quarter and line cores
// - Outside data only via display/buffer registers
// - Character drawn with at most twelve strokes
// - Strokes single/double, sixteen directions, from rest; decode gives fourteen directions
// - Intensity normal, double or blanked
// - Equal deflection time; double length doubles intensity
// - Six rows, odd then even stroke per row
// - Inhibit all rows but one; capture pair
// - First five bits weighted 1 to 16
// - Decode 5-bit code to X/Y move
// - Sixth bit set means visible stroke
// - Code 16 ends the character
// - Short characters carry end code after last
// - Eleven or more strokes run all twelve
// - Ring started by phase five, ends on end/twelve
// - Step one drives line; step two strobes, advances
module ccsg_core
  import ccsg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_cycle_launch_pulse,  // Start of one memory cycle
  input wire logic [CCSG_ADDR_W-1:0] i_addr,  // Location to cycle
  input wire logic i_ext_load,  // Write display/buffer data instead of recirculating
  input wire logic [CCSG_DATA_W-1:0] i_ext_data,  // Display or buffer register contents
  input wire logic [CCSG_DATA_W-1:0] i_sense,  // Memory sense amplifiers
  input wire logic [CCSG_ROW_W-1:0] i_rope_sense,  // Pattern store sense windings
  input wire logic i_beam_ready,  // Deflection circuitry accepts a move
  output logic o_phase_one,
  output logic o_phase_two,
  output logic o_phase_three,
  output logic o_phase_four,
  output logic o_phase_five_trigger,
  output logic o_read_drive_pulse,
  output logic o_write_drive_pulse,
  output logic o_sense_capture_strobe,
  output logic o_line_core_master_reset,
  output logic o_quarter_core_master_reset,
  output ccsg_axis_t o_x_sel,  // X axis address cores
  output ccsg_axis_t o_y_sel,  // Y axis address cores
  output logic [CCSG_DATA_W-1:0] o_plane_inhibit_term,
  output logic [CCSG_DATA_W-1:0] o_memory_info_register,
  output logic o_symbol_drive_pulse,
  output logic [CCSG_ROWS-1:0] o_row_inhibit,  // High rows carry inhibit current
  output logic o_stroke_sense_strobe,
  output logic o_stroking,  // Character in progress
  output logic o_char_done,  // One pulse when a character ends
  output logic o_move_valid,
  output ccsg_move_t o_move
);

  typedef enum logic [1:0] {CCSG_RING_IDLE, CCSG_RING_DRIVE, CCSG_RING_SENSE,
    CCSG_RING_EMIT} ccsg_ring_t;

  logic [CCSG_PHASES-1:0] phase_reg;  // One-hot memory time shift register
  logic [CCSG_ADDR_W-1:0] addr_reg;  // Latched address for the whole cycle
  logic [CCSG_DATA_W-1:0] mir_reg;  // Memory information register
  logic [CCSG_DATA_W-1:0] wdata_reg;  // Data to write back
  ccsg_ring_t ring_reg;  // Stroke timing step
  logic [CCSG_ROWS-1:0] row_reg;  // One-hot selected row, others inhibited
  logic [CCSG_ROW_W-1:0] pair_reg;  // Stroke storage: odd and even
  logic [3:0] stroke_cnt_reg;  // Strokes handled so far
  logic half_reg;  // Low = odd stroke, high = even
  logic done_reg;  // Character end pulse
  logic fifo_ready;
  logic [CCSG_STROKE_W-1:0] cur_stroke;
  logic is_eoc;
  ccsg_move_t cur_move;
  logic push;
  logic last;

  // Decode one 5-bit stroke code into a move; used for both halves
  function automatic ccsg_move_t ccsg_decode(input logic [CCSG_STROKE_W-1:0] s);
    ccsg_move_t m;
    logic signed [2:0] x;
    logic signed [2:0] y;
    logic dbl;
    x = 3'sd0;
    y = 3'sd0;
    case (s[4:0])
      5'h01, 5'h09: begin x = -3'sd1; y = -3'sd1; end
      5'h02: y = -3'sd1;
      5'h03, 5'h0b: begin x = -3'sd2; y = -3'sd2; end
      5'h04: x = -3'sd1;
      5'h05: begin x = 3'sd1; y = -3'sd1; end
      5'h06: x = -3'sd2;
      5'h07: begin x = -3'sd2; y = -3'sd1; end
      5'h0a: y = -3'sd2;
      5'h0d: begin x = 3'sd1; y = -3'sd2; end
      5'h0f: begin x = 3'sd2; y = -3'sd2; end
      5'h11: begin x = -3'sd1; y = 3'sd1; end
      5'h12: y = 3'sd1;
      5'h13: begin x = -3'sd2; y = 3'sd1; end
      5'h14: x = 3'sd1;
      5'h15: begin x = 3'sd1; y = 3'sd1; end
      5'h16: x = 3'sd2;
      5'h17: begin x = 3'sd2; y = 3'sd1; end
      5'h19: begin x = -3'sd1; y = 3'sd2; end
      5'h1a: y = 3'sd2;
      5'h1b: begin x = -3'sd2; y = 3'sd2; end
      5'h1d: begin x = 3'sd1; y = 3'sd2; end
      5'h1f: begin x = 3'sd2; y = 3'sd2; end
      default: begin x = 3'sd0; y = 3'sd0; end  // Unused and end code: no move
    endcase
    dbl = (x == 3'sd2) || (x == -3'sd2) || (y == 3'sd2) || (y == -3'sd2);
    m.dx = x;
    m.dy = y;
    // Deflection time is fixed, so longer moves need twice the beam
    if (!s[CCSG_INTENS_BIT])
      m.intensity = CCSG_INT_BLANK;
    else if (dbl)
      m.intensity = CCSG_INT_DOUBLE;
    else
      m.intensity = CCSG_INT_NORMAL;
    return m;
  endfunction : ccsg_decode

  // One-hot of a 2-bit or 3-bit field, shared by the two axes
  function automatic ccsg_axis_t ccsg_axis(input logic [4:0] line);
    ccsg_axis_t a;
    a.quarter = CCSG_QUARTERS'(1) << line[4:3];  // Quarter core, two terms
    a.line = CCSG_LINE_SEL'(1) << line[2:0];  // Line core, three terms
    return a;
  endfunction : ccsg_axis

  // Memory time shift register; a launch mid-cycle is ignored
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      phase_reg <= CCSG_PHASE_RST;
    end
    else if (i_cycle_launch_pulse && (phase_reg == '0))
    begin
      phase_reg <= CCSG_PHASES'(1);
    end
    else
    begin
      phase_reg <= phase_reg << 1;
    end
  end

  assign o_phase_one = phase_reg[0];
  assign o_phase_two = phase_reg[1];
  assign o_phase_three = phase_reg[2];
  assign o_phase_four = phase_reg[3];
  assign o_phase_five_trigger = phase_reg[4];
  assign o_read_drive_pulse = phase_reg[0] | phase_reg[1];
  assign o_sense_capture_strobe = phase_reg[1];
  assign o_write_drive_pulse = phase_reg[2] | phase_reg[3];
  assign o_line_core_master_reset = phase_reg[2];
  assign o_quarter_core_master_reset = phase_reg[2];
  // Planes whose bit is zero carry inhibit during the write
  assign o_plane_inhibit_term = o_write_drive_pulse ? ~wdata_reg : '0;
  // Cores are held set from phase one until the master reset
  assign o_x_sel = (phase_reg[0] | phase_reg[1]) ? ccsg_axis(addr_reg[4:0]) : '0;
  assign o_y_sel = (phase_reg[0] | phase_reg[1]) ? ccsg_axis(addr_reg[9:5]) : '0;
  assign o_memory_info_register = mir_reg;

  // Address latch at launch so it stays steady through the cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      addr_reg <= '0;
    end
    else if (i_cycle_launch_pulse && (phase_reg == '0))
    begin
      addr_reg <= i_addr;
    end
  end

  // Information register and write-back data
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mir_reg <= '0;
      wdata_reg <= '0;
    end
    else if (phase_reg[1])
    begin
      mir_reg <= i_sense;
      // Outside data enters only from the display/buffer word
      wdata_reg <= i_ext_load ? i_ext_data : i_sense;
    end
  end

  // Current stroke, end test and decoded move
  assign cur_stroke = half_reg ? pair_reg[CCSG_ROW_W-1:CCSG_STROKE_W]
                               : pair_reg[CCSG_STROKE_W-1:0];
  assign is_eoc = (cur_stroke[4:0] == CCSG_CODE_EOC);
  assign cur_move = ccsg_decode(cur_stroke);
  assign push = (ring_reg == CCSG_RING_EMIT) && !is_eoc && fifo_ready;
  assign last = (stroke_cnt_reg == 4'(CCSG_MAX_STROKES - 1));

  // Stroke timing ring
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ring_reg <= CCSG_RING_IDLE;
      row_reg <= CCSG_ROW_RST;
      pair_reg <= '0;
      stroke_cnt_reg <= CCSG_CNT_RST;
      half_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      case (ring_reg)
        CCSG_RING_IDLE:
        begin
          if (phase_reg[4])
          begin
            ring_reg <= CCSG_RING_DRIVE;
            row_reg <= CCSG_ROW_RST;
            stroke_cnt_reg <= CCSG_CNT_RST;
            half_reg <= 1'b0;
          end
        end
        CCSG_RING_DRIVE:
        begin
          ring_reg <= CCSG_RING_SENSE;  // Drive line pulsed this step
        end
        CCSG_RING_SENSE:
        begin
          pair_reg <= i_rope_sense;
          row_reg <= {row_reg[CCSG_ROWS-2:0], row_reg[CCSG_ROWS-1]};
          half_reg <= 1'b0;
          ring_reg <= CCSG_RING_EMIT;
        end
        CCSG_RING_EMIT:
        begin
          if (is_eoc || (fifo_ready && last))
          begin
            ring_reg <= CCSG_RING_IDLE;
            done_reg <= 1'b1;
          end
          else if (fifo_ready)
          begin
            // Stall on a full buffer, so no stroke is lost
            stroke_cnt_reg <= stroke_cnt_reg + 4'h1;
            half_reg <= ~half_reg;
            if (half_reg)
            begin
              ring_reg <= CCSG_RING_DRIVE;  // Next row
            end
          end
        end
        default: ring_reg <= CCSG_RING_IDLE;
      endcase
    end
  end

  assign o_symbol_drive_pulse = (ring_reg == CCSG_RING_DRIVE);
  assign o_stroke_sense_strobe = (ring_reg == CCSG_RING_SENSE);
  // While stroking, only the selected row is free of inhibit current
  assign o_row_inhibit = (ring_reg == CCSG_RING_IDLE) ? '0 : ~row_reg;
  assign o_stroking = (ring_reg != CCSG_RING_IDLE);
  assign o_char_done = done_reg;

  // Decoded moves buffered toward the deflection drive
  ccsg_fifo #(
    .WIDTH($bits(ccsg_move_t)),
    .DEPTH(CCSG_FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_valid(push),
    .o_in_ready(fifo_ready),
    .i_in_data(cur_move),
    .o_out_valid(o_move_valid),
    .i_out_ready(i_beam_ready),
    .o_out_data(o_move)
  );

endmodule : ccsg_core

module ccsg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // Flip-flop storage
  logic [AW-1:0] wr_reg;  // Write index
  logic [AW-1:0] rd_reg;  // Read index
  logic [AW:0] cnt_reg;  // Fill level, one bit wider so full and empty differ
  logic push;
  logic pop;

  assign o_in_ready = (cnt_reg != (AW + 1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Storage write; no reset needed on data
  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  // Pointers and fill level; push and pop in one cycle leave the level unchanged
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + AW'(1);
      end
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // Head word; storage itself is flip-flops
  assign o_out_data = mem_reg[rd_reg];

endmodule : ccsg_fifo

// [design/ccsg_pkg.sv]
package ccsg_pkg;

  // Memory organisation
  localparam int CCSG_DATA_W = 6;
  localparam int CCSG_ADDR_W = 10;
  localparam int CCSG_PHASES = 5;
  localparam int CCSG_LINES = 32;
  localparam int CCSG_QUARTERS = 4;
  localparam int CCSG_LINE_SEL = 8;

  // Pattern store
  localparam int CCSG_ROWS = 6;
  localparam int CCSG_STROKE_W = 6;
  localparam int CCSG_ROW_W = 12;
  localparam int CCSG_MAX_STROKES = 12;
  localparam logic [4:0] CCSG_CODE_EOC = 5'h10;
  localparam int CCSG_INTENS_BIT = 5;

  // Buffer depth in front of the beam drive
  localparam int CCSG_FIFO_DEPTH = 32;

  // Reset values
  localparam logic [4:0] CCSG_PHASE_RST = 5'h00;
  localparam logic [5:0] CCSG_ROW_RST = 6'h01;
  localparam logic [3:0] CCSG_CNT_RST = 4'h0;

  // Intensity levels
  typedef enum logic [1:0] {CCSG_INT_BLANK, CCSG_INT_NORMAL, CCSG_INT_DOUBLE} ccsg_int_t;

  // One decoded beam move
  typedef struct packed {
    logic signed [2:0] dx;
    logic signed [2:0] dy;
    ccsg_int_t intensity;
  } ccsg_move_t;

  // Address core selection for one axis
  typedef struct packed {
    logic [CCSG_QUARTERS-1:0] quarter;
    logic [CCSG_LINE_SEL-1:0] line;
  } ccsg_axis_t;

endpackage : ccsg_pkg

// [design/ccsg_fifo.sv]
// The move buffer is defined beside the core so that all logic sits together

// [tb/ccsg_checker.sv]
module ccsg_checker
  import ccsg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_cycle_launch_pulse,
  input wire logic [CCSG_DATA_W-1:0] i_sense,
  input wire logic i_ext_load,
  input wire logic [CCSG_DATA_W-1:0] i_ext_data,
  input wire logic o_phase_one,
  input wire logic o_phase_two,
  input wire logic o_phase_three,
  input wire logic o_phase_four,
  input wire logic o_phase_five_trigger,
  input wire logic o_read_drive_pulse,
  input wire logic o_write_drive_pulse,
  input wire logic o_sense_capture_strobe,
  input wire logic o_line_core_master_reset,
  input wire logic o_quarter_core_master_reset,
  input wire ccsg_axis_t o_x_sel,
  input wire ccsg_axis_t o_y_sel,
  input wire logic [CCSG_DATA_W-1:0] o_plane_inhibit_term,
  input wire logic [CCSG_DATA_W-1:0] o_memory_info_register,
  input wire logic o_symbol_drive_pulse,
  input wire logic [CCSG_ROWS-1:0] o_row_inhibit,
  input wire logic o_stroke_sense_strobe,
  input wire logic o_char_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // Any phase high means a launch must be ignored
  wire busy = o_phase_one | o_phase_two | o_phase_three | o_phase_four | o_phase_five_trigger;
  logic [3:0] strobe_cnt_reg;  // Row strobes in this character, six rows at most
  // Counter restarts on each character end
  always_ff @(posedge i_clk_sys or negedge i_nrst)
    if (!i_nrst)
      strobe_cnt_reg <= 4'h0;
    else if (o_char_done)
      strobe_cnt_reg <= 4'h0;
    else
      strobe_cnt_reg <= strobe_cnt_reg + {3'h0, o_stroke_sense_strobe};
  phase_order_a:
  assert property (o_phase_one |=> o_phase_two ##1 o_phase_three ##1 o_phase_four
    ##1 o_phase_five_trigger) else $error("phase order broken");
  launch_take_a:
  assert property (i_cycle_launch_pulse && !busy |=> o_phase_one) else $error("launch lost");
  read_window_a:
  assert property (o_read_drive_pulse == (o_phase_one || o_phase_two)) else $error("read window");
  write_window_a:
  assert property (o_write_drive_pulse == (o_phase_three || o_phase_four))
    else $error("write window");
  master_reset_a:
  assert property ((o_line_core_master_reset == o_phase_three)
    && (o_quarter_core_master_reset == o_phase_three)) else $error("master reset");
  sense_strobe_a:
  assert property (o_sense_capture_strobe == o_phase_two) else $error("sense strobe");
  core_select_a:
  assert property (o_phase_one |-> $onehot(o_x_sel.quarter) && $onehot(o_x_sel.line)
    && $onehot(o_y_sel.quarter) && $onehot(o_y_sel.line)) else $error("core select");
  mir_load_a:
  assert property (o_phase_two |=> o_memory_info_register == $past(i_sense))
    else $error("info register load");
  inhibit_data_a:
  assert property (o_phase_three || o_phase_four |-> o_plane_inhibit_term
    == ~(i_ext_load ? i_ext_data : o_memory_info_register)) else $error("inhibit terms");
  ring_start_a:
  assert property (o_phase_five_trigger |=> o_symbol_drive_pulse) else $error("ring start");
  row_select_a:
  assert property (o_symbol_drive_pulse |-> $countones(o_row_inhibit) == 5
    ##1 o_stroke_sense_strobe) else $error("row select");
  stroke_limit_a:
  assert property (strobe_cnt_reg <= 4'h6) else $error("too many rows");
  cover property (o_char_done);
  cover property (o_phase_five_trigger);
  cover property (o_symbol_drive_pulse && o_row_inhibit == 6'h1f);
endmodule : ccsg_checker

bind ccsg_core ccsg_checker ccsg_checker_i (.*);

// [tb/ccsg_beam_model.sv]
module ccsg_beam_model
  import ccsg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_stall,  // Hold the beam busy
  input wire logic i_move_valid,
  input wire ccsg_move_t i_move,
  output logic o_beam_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h13e6;
  ccsg_move_t seen [$];  // Every move the deflection side took
  initial o_beam_ready = 1'b0;
  // Ready moves off the sampling edge; a slow beam refuses about one cycle in four
  always @(negedge i_clk_sys)
    o_beam_ready <= !i_stall && ($random(seed) % 4 != 0);
  // A move is taken only on an edge with both valid and ready
  always @(posedge i_clk_sys)
    if (i_nrst && i_move_valid && o_beam_ready)
      seen.push_back(i_move);
endmodule : ccsg_beam_model

// [tb/testbench.sv]
module testbench
  import ccsg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // Two digits per code: x and y move plus two
  localparam string DIRS = "2211210012310201221120002230224022132303323342432214240422342244";
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_cycle_launch_pulse = 1'b0;
  logic i_ext_load = 1'b0;
  logic [9:0] i_addr = 10'h000;
  logic [5:0] i_ext_data = 6'h00;
  logic [5:0] i_sense = 6'h00;
  logic [11:0] i_rope_sense = 12'h000;
  logic i_beam_ready, stall = 1'b1;
  logic o_phase_one, o_phase_two, o_phase_three, o_phase_four, o_phase_five_trigger;
  logic o_read_drive_pulse, o_write_drive_pulse, o_sense_capture_strobe, o_symbol_drive_pulse;
  logic o_line_core_master_reset, o_quarter_core_master_reset, o_stroke_sense_strobe;
  logic o_stroking, o_char_done, o_move_valid;
  ccsg_axis_t o_x_sel, o_y_sel;
  logic [5:0] o_plane_inhibit_term, o_memory_info_register, o_row_inhibit;
  ccsg_move_t o_move;
  logic [5:0] pat [12];  // Strokes wired for the current character
  logic [7:0] expq [$];  // Moves the beam should receive
  int seed = 32'h13e6;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  ccsg_core ccsg_core_i (.*);
  ccsg_beam_model ccsg_beam_model_i (.i_clk_sys, .i_nrst, .i_stall(stall),
    .i_move_valid(o_move_valid), .i_move(o_move), .o_beam_ready(i_beam_ready));
  always #25 i_clk_sys = ~i_clk_sys;
  // Only the one uninhibited row answers; otherwise the windings show noise
  always @(negedge i_clk_sys)
  begin
    i_rope_sense = ~i_rope_sense;
    for (int r = 0; r < CCSG_ROWS; r++)
      if (o_row_inhibit == ~(6'h01 << r))
        i_rope_sense = {pat[2*r+1], pat[2*r]};
  end
  // Hang guard
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 32'hea60)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Character k: sweep of all codes but the end code, then end codes at set places, then random
  task automatic make_pat(input int k);
    for (int i = 0; i < CCSG_MAX_STROKES; i++)
    begin
      pat[i] = 6'($random(seed));
      if (k < 3)
        pat[i][4:0] = 5'((k * 11 + i) % 32);
      if (pat[i][4:0] == CCSG_CODE_EOC)
        pat[i][0] = 1'b1;
      if (k inside {[3:5]} && i == (k == 3 ? 4 : k == 4 ? 9 : 0))
        pat[i][4:0] = CCSG_CODE_EOC;
    end
  endtask : make_pat
  // Stroke list up to the end code, intensity doubled with the length
  task automatic expect_char();
    int dx, dy, c;
    for (int i = 0; i < CCSG_MAX_STROKES; i++)
    begin
      c = pat[i][4:0];
      if (c == 16)
        break;
      dx = DIRS[2*c] - 8'h32;
      dy = DIRS[2*c+1] - 8'h32;
      expq.push_back({3'(dx), 3'(dy),
        pat[i][5] ? ((dx * dx == 4 || dy * dy == 4) ? 2'h2 : 2'h1) : 2'h0});
    end
  endtask : expect_char
  task automatic wait_char();
    for (int n = 0; n < 3000 && o_char_done !== 1'b1; n++)
      @(negedge i_clk_sys);
    check("char_done", o_char_done, 1);
  endtask : wait_char
  task automatic drain();
    for (int n = 0; n < 3000 && ccsg_beam_model_i.seen.size() < expq.size(); n++)
      @(negedge i_clk_sys);
    check("count", ccsg_beam_model_i.seen.size(), expq.size());
    foreach (expq[i])
      check("move", ccsg_beam_model_i.seen[i], expq[i]);
    expq.delete();
    ccsg_beam_model_i.seen.delete();
  endtask : drain
  // One memory cycle with random data, launch held into phase one
  task automatic run_char(input bit wait_done);
    logic [5:0] wb;
    @(negedge i_clk_sys);
    {i_addr, i_sense, i_ext_data, i_ext_load} = 23'($random(seed));
    i_cycle_launch_pulse = 1'b1;
    expect_char();
    @(negedge i_clk_sys);
    check("phase_one", o_phase_one, 1);
    // Quarter core from the upper two line bits, line core from the lower three
    check("x_sel", o_x_sel, {4'h1 << i_addr[4:3], 8'h01 << i_addr[2:0]});
    check("y_sel", o_y_sel, {4'h1 << i_addr[9:8], 8'h01 << i_addr[7:5]});
    @(negedge i_clk_sys);
    i_cycle_launch_pulse = 1'b0;
    check("relaunch", o_phase_one, 0);
    @(negedge i_clk_sys);
    wb = ~(i_ext_load ? i_ext_data : i_sense);
    check("inhibit", o_plane_inhibit_term, wb);
    check("mir", o_memory_info_register, i_sense);
    if (wait_done)
      wait_char();
  endtask : run_char
  initial
  begin
    repeat (2) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    check("idle", {o_read_drive_pulse, o_write_drive_pulse, o_symbol_drive_pulse}, 0);
    // Beam stalled: three characters overfill the buffer and hold the ring
    for (int k = 0; k < 3; k++)
    begin
      make_pat(k);
      run_char(k < 2);
    end
    repeat (300) @(negedge i_clk_sys);
    check("ring_held", o_stroking, 1);
    stall = 1'b0;
    wait_char();
    drain();
    for (int k = 3; k < 20; k++)
    begin
      make_pat(k);
      run_char(1'b1);
      drain();
    end
    summarize();
  end
endmodule : testbench
